// ---- design/pfi_routing_pkg.sv ----
// Package for the programmable function pin routing block.
// Assumes a single 20 MHz clock and an APB register slave.
package pfi_routing_pkg;

  // ==========================================================================
  // Sizes and timing
  localparam int          PIN_COUNT        = 10;
  localparam int          SIGNAL_COUNT     = 13;
  localparam int          DEDICATED_COUNT  = 5;
  localparam int          CLOCK_PERIOD_NS  = 50;
  // Start trigger pulse 50..100 ns: least time rounds up
  localparam int          TRIG_PULSE_NS    = 50;
  localparam int          TRIG_PULSE_CYC   = (TRIG_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  // Scan clock delay 50..100 ns, width 400..500 ns
  localparam int          SCAN_DELAY_NS    = 50;
  localparam int          SCAN_DELAY_CYC   = (SCAN_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int          SCAN_WIDTH_NS    = 400;
  localparam int          SCAN_WIDTH_CYC   = (SCAN_WIDTH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  // Strobe burst clocks
  localparam int          STROBE_SLOW_NS   = 10000;
  localparam int          STROBE_FAST_NS   = 1200;
  localparam int          STROBE_SLOW_CYC  = STROBE_SLOW_NS / CLOCK_PERIOD_NS;
  localparam int          STROBE_FAST_CYC  = STROBE_FAST_NS / CLOCK_PERIOD_NS;
  localparam int          STROBE_PULSES    = 8;

  // ==========================================================================
  // Internal timing signal indices (source selection slots)
  localparam int          SIG_START_TRIG   = 0;
  localparam int          SIG_POST_TRIG    = 1;
  localparam int          SIG_CONVERT      = 2;
  localparam int          SIG_SCAN_BEGIN   = 3;
  localparam int          SIG_GATE         = 4;
  localparam int          SIG_SCAN_SRC     = 5;
  // Pins that carry a fixed output
  localparam int          PIN_START_TRIG   = 0;
  localparam int          PIN_POST_TRIG    = 1;
  localparam int          PIN_CONVERT      = 2;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] OFS_CONTROL      = 12'h000;
  localparam logic [11:0] OFS_PIN_OE       = 12'h004;
  localparam logic [11:0] OFS_POLARITY     = 12'h008;
  localparam logic [11:0] OFS_COMMAND      = 12'h00C;
  localparam logic [11:0] OFS_STATUS       = 12'h010;
  localparam logic [11:0] OFS_POST_SCANS   = 12'h014;
  localparam logic [11:0] OFS_SELECT_BASE  = 12'h040;

  // Control register fields
  localparam int          CTL_PRETRIG      = 0;
  localparam int          CTL_SCAN_SAMPLE_CLOCK_OUT_EN   = 1;
  localparam int          CTL_SCAN_SAMPLE_CLOCK_OUT_POL  = 2;
  localparam int          CTL_STROBE_HW    = 3;
  localparam int          CTL_STROBE_LVL   = 4;
  localparam int          CTL_STROBE_FAST  = 5;
  localparam int          CTL_ANALOG_TRIG  = 6;
  localparam int          CTL_DEDIC_OE     = 7;
  // Command register fields (write one to act)
  localparam int          CMD_SW_TRIG      = 0;
  localparam int          CMD_STROBE_GO    = 1;
  localparam int          CMD_STOP         = 2;

  // Reset values: everything off, strobe idles high, source pin 0
  localparam logic [31:0] CONTROL_RESET    = 32'h0000_0010;
  localparam logic [3:0]  SELECT_RESET     = 4'h0;
  localparam logic [15:0] POST_SCANS_RESET = 16'h0010;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    ACQ_IDLE = 2'b00,
    ACQ_PRE  = 2'b01,
    ACQ_POST = 2'b10
  } acq_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic [PIN_COUNT-1:0] out;
    logic [PIN_COUNT-1:0] oe;
  } pin_drive_t;

endpackage

// ---- design/pfi_trigger_routing.sv ----
// Programmable function pin routing and acquisition trigger outputs.
// Assumes pins are asynchronous inputs; a bench resolves the pin wires.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// How it works
// [RL1] Ten two-way function pins carry all external timing control.
// [RL2] Each of thirteen internal signals picks its source pin by register.
// [RL3] Each pin has its own enable and drives a fixed internal signal; here only pins 0 and 2 drive a signal, the rest drive low.
// [RL4] Five dedicated outputs carry the remaining timing signals.
// [RL5] Outside equipment must not drive a pin whose driver is on.
// [RL6] Each input has polarity; edge or level follows the signal.
// [RL7] Scan clock starts 50-100 ns after conversion and lasts 400-500 ns.
// [RL8] Scan clock is output only, software enabled, polarity selectable.
// [RL9] Single-pulse mode: strobe level follows a software-written bit.
// [RL10] Hardware mode: eight strobe pulses from a 10 us or 1.2 us clock.
// [RL11] Start trigger is edge detected from any pin, polarity chooses edge.
// [RL12] Start trigger edge begins acquisition in pre and post modes.
// [RL13] Start trigger output shows the real starting event from any source.
// [RL14] Start trigger output is an active-high 50-100 ns pulse.
// [RL15] Start trigger output is tri-state until software enables it.
// [RL16] Pin 0 drives the start trigger, pin 2 the conversion pulse.
// [RL17] Optional analog threshold trigger on pin 0 acts as start source.
// [RL18] Software command may issue the start trigger.
// [RL19] Pretrigger keeps samples before and after; posttrigger only after.
// [RL20] Posttrigger edge starts post phase; fixed scans then stop.
// [RL21] Pin inputs are synchronised before detection.
// [RL22] Reset leaves selections defined and every output disabled.
module pfi_trigger_routing #(
  parameter int PINS    = pfi_routing_pkg::PIN_COUNT,
  parameter int SIGNALS = pfi_routing_pkg::SIGNAL_COUNT
) (
  input  wire logic                     clock_i,           // 20 MHz clock
  input  wire logic                     nrst_i,            // Sync reset, low
  input  wire pfi_routing_pkg::apb_req_t apb_req_i,        // APB request
  output pfi_routing_pkg::apb_rsp_t     apb_rsp_o,         // APB answer
  input  wire logic [PINS-1:0]          pin_in_i,          // Pin levels
  output logic [PINS-1:0]               pin_out_o,         // Pin drive values
  output logic [PINS-1:0]               pin_oe_o,          // Pin drive enables
  input  wire logic                     analog_trig_i,     // Threshold trigger
  input  wire logic                     convert_pulse_i,   // Conversion start
  input  wire logic                     scan_done_i,       // Scan finished
  output logic [SIGNALS-1:0]            signal_event_o,    // Routed inputs
  output logic                          acquiring_o,       // Sequence running
  output logic                          keep_pretrig_o,    // Keep early samples
  output logic                          scan_sample_clock_out_o, // Scan clock
  output logic                          external_strobe_n_o,     // Strobe, low
  output logic                          dedicated_oe_o     // Dedicated enables
);

  // ==========================================================================
  // State record
  typedef struct packed {
    logic [31:0]               control;
    logic [PINS-1:0]           pin_oe;
    logic [PINS-1:0]           polarity;
    logic [SIGNALS-1:0][3:0]   select;
    logic [15:0]               post_scans;
    logic [PINS-1:0]           sync1;
    logic [PINS-1:0]           sync2;
    logic [PINS-1:0]           sync3;
    logic [1:0]                acq;
    logic [15:0]               scan_cnt;
    logic [3:0]                trig_cnt;
    logic [3:0]                conv_cnt;
    logic [4:0]                delay_cnt;
    logic [4:0]                width_cnt;
    logic                      scan_sample_clock_out;
    logic [7:0]                div_cnt;
    logic [4:0]                strobe_cnt;
    logic                      strobe;
    logic                      ready;
    logic [31:0]               rdata;
  } state_t;

  state_t st;
  state_t next_st;

  // Picks a pin bit by index; out of range reads zero
  function automatic logic pick(input logic [PINS-1:0] v, input logic [3:0] i);
    pick = (int'(i) < PINS) ? v[i] : 1'b0;
  endfunction

  // Address inside the source selection table; a truncated index alone aliases
  function automatic logic sel_hit(input logic [11:0] a);
    sel_hit = a >= pfi_routing_pkg::OFS_SELECT_BASE &&
              a < pfi_routing_pkg::OFS_SELECT_BASE + 12'(4 * SIGNALS);
  endfunction

  // ==========================================================================
  // Input detection per signal
  logic [PINS-1:0]    level_pol;
  logic [PINS-1:0]    edge_pol;
  logic [SIGNALS-1:0] routed_level;
  logic [SIGNALS-1:0] routed_edge;

  // First stage only feeds second; level uses the second, edge compares the two later stages
  assign level_pol = st.sync2 ^ st.polarity;                       // RL6 RL21
  assign edge_pol  = (st.sync2 ^ st.polarity) & ~(st.sync3 ^ st.polarity);

  genvar g;
  generate
    for (g = 0; g < SIGNALS; g++) begin : g_route
      // Source pin per signal selected by software
      assign routed_level[g] = pick(level_pol, st.select[g]);      // RL2
      assign routed_edge[g]  = pick(edge_pol, st.select[g]);       // RL11
      // Gate and scan source are level signals, the rest edge
      assign signal_event_o[g] = (g == pfi_routing_pkg::SIG_GATE ||
                                  g == pfi_routing_pkg::SIG_SCAN_SRC) ?
                                 routed_level[g] : routed_edge[g]; // RL6
    end
  endgenerate

  // ==========================================================================
  // Next state
  logic       wr;
  logic       rd;
  logic [3:0] sel_idx;
  logic       start_evt;
  logic       post_evt;
  logic [7:0] div_max;

  // Writes land on the edge that completes the transfer, with pready high
  assign wr      = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite & st.ready;
  assign rd      = apb_req_i.psel & ~apb_req_i.penable & ~apb_req_i.pwrite;
  assign sel_idx = 4'((apb_req_i.paddr - pfi_routing_pkg::OFS_SELECT_BASE) >> 2);
  assign div_max = st.control[pfi_routing_pkg::CTL_STROBE_FAST] ?
                   8'(pfi_routing_pkg::STROBE_FAST_CYC - 1) :
                   8'(pfi_routing_pkg::STROBE_SLOW_CYC - 1);

  // Pin edge, analog threshold or software command start a sequence
  assign start_evt = routed_edge[pfi_routing_pkg::SIG_START_TRIG]  // RL11
    | (st.control[pfi_routing_pkg::CTL_ANALOG_TRIG] & analog_trig_i) // RL17
    | (wr && apb_req_i.paddr == pfi_routing_pkg::OFS_COMMAND &&
       apb_req_i.pwdata[pfi_routing_pkg::CMD_SW_TRIG]);            // RL18
  assign post_evt  = routed_edge[pfi_routing_pkg::SIG_POST_TRIG];

  always_comb begin
    next_st       = st;
    next_st.ready = 1'b0;
    next_st.sync1 = pin_in_i;                                      // RL21
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;

    // Register access: answer in second access cycle
    if (apb_req_i.psel && apb_req_i.penable && !st.ready) begin
      next_st.ready = 1'b1;
    end
    if (rd) begin
      next_st.rdata = 32'h0000_0000;
      unique case (apb_req_i.paddr)
        pfi_routing_pkg::OFS_CONTROL:    next_st.rdata = st.control;
        pfi_routing_pkg::OFS_PIN_OE:     next_st.rdata = 32'(st.pin_oe);
        pfi_routing_pkg::OFS_POLARITY:   next_st.rdata = 32'(st.polarity);
        pfi_routing_pkg::OFS_STATUS:     next_st.rdata = {24'h000000, st.strobe_cnt != 5'h00,
                                                          st.scan_sample_clock_out, 4'h0, st.acq};
        pfi_routing_pkg::OFS_POST_SCANS: next_st.rdata = {16'h0000, st.post_scans};
        default: begin
          if (sel_hit(apb_req_i.paddr))
            next_st.rdata = {28'h0000000, st.select[sel_idx]};
        end
      endcase
    end
    if (wr) begin
      unique case (apb_req_i.paddr)
        pfi_routing_pkg::OFS_CONTROL:    next_st.control    = apb_req_i.pwdata;  // RL8 RL9
        pfi_routing_pkg::OFS_PIN_OE:     next_st.pin_oe     = apb_req_i.pwdata[PINS-1:0]; // RL3
        pfi_routing_pkg::OFS_POLARITY:   next_st.polarity   = apb_req_i.pwdata[PINS-1:0];
        pfi_routing_pkg::OFS_POST_SCANS: next_st.post_scans = apb_req_i.pwdata[15:0];
        pfi_routing_pkg::OFS_COMMAND: begin
          if (apb_req_i.pwdata[pfi_routing_pkg::CMD_STROBE_GO])
            next_st.strobe_cnt = 5'(2 * pfi_routing_pkg::STROBE_PULSES);
          if (apb_req_i.pwdata[pfi_routing_pkg::CMD_STOP])
            next_st.acq = 2'(pfi_routing_pkg::ACQ_IDLE);
        end
        default: begin
          if (sel_hit(apb_req_i.paddr))
            next_st.select[sel_idx] = apb_req_i.pwdata[3:0];       // RL2
        end
      endcase
    end

    // Acquisition sequence
    unique case (pfi_routing_pkg::acq_state_t'(st.acq))
      pfi_routing_pkg::ACQ_IDLE: begin
        if (start_evt) begin                                       // RL12
          next_st.trig_cnt = 4'(pfi_routing_pkg::TRIG_PULSE_CYC);  // RL13 RL14
          next_st.scan_cnt = st.post_scans;
          // Pretrigger waits for the second trigger before counting
          next_st.acq = st.control[pfi_routing_pkg::CTL_PRETRIG] ?
                        2'(pfi_routing_pkg::ACQ_PRE) : 2'(pfi_routing_pkg::ACQ_POST); // RL19
        end
      end
      pfi_routing_pkg::ACQ_PRE: begin
        if (post_evt) next_st.acq = 2'(pfi_routing_pkg::ACQ_POST);  // RL20
      end
      pfi_routing_pkg::ACQ_POST: begin
        // Fixed number of scans, then stop
        if (scan_done_i) begin
          if (st.scan_cnt <= 16'h0001) next_st.acq = 2'(pfi_routing_pkg::ACQ_IDLE); // RL20
          next_st.scan_cnt = st.scan_cnt - 16'h0001;
        end
      end
      default: next_st.acq = 2'(pfi_routing_pkg::ACQ_IDLE);
    endcase
    if (st.trig_cnt != 4'h0) next_st.trig_cnt = st.trig_cnt - 4'h1;

    // Conversion output pulse and scan clock timing
    if (convert_pulse_i && st.acq != 2'(pfi_routing_pkg::ACQ_IDLE)) begin
      next_st.conv_cnt  = 4'(pfi_routing_pkg::TRIG_PULSE_CYC);
      next_st.delay_cnt = 5'(pfi_routing_pkg::SCAN_DELAY_CYC);     // RL7
    end else if (st.conv_cnt != 4'h0) begin
      next_st.conv_cnt = st.conv_cnt - 4'h1;
    end
    if (st.delay_cnt != 5'h00) begin
      next_st.delay_cnt = st.delay_cnt - 5'h01;
      if (st.delay_cnt == 5'h01) begin
        next_st.scan_sample_clock_out   = 1'b1;
        next_st.width_cnt = 5'(pfi_routing_pkg::SCAN_WIDTH_CYC);   // RL7
      end
    end else if (st.width_cnt != 5'h00) begin
      next_st.width_cnt = st.width_cnt - 5'h01;
      if (st.width_cnt == 5'h01) next_st.scan_sample_clock_out = 1'b0;
    end

    // Strobe burst: divider enable toggles strobe sixteen times
    if (st.strobe_cnt != 5'h00) begin
      if (st.div_cnt >= div_max) begin
        next_st.div_cnt    = 8'h00;
        next_st.strobe_cnt = st.strobe_cnt - 5'h01;
        next_st.strobe     = ~st.strobe;                           // RL10
      end else begin
        next_st.div_cnt = st.div_cnt + 8'h01;
      end
    end else begin
      next_st.div_cnt = 8'h00;
      next_st.strobe  = 1'b1;
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      st            <= '0;                                         // RL22
      st.control    <= pfi_routing_pkg::CONTROL_RESET;
      st.post_scans <= pfi_routing_pkg::POST_SCANS_RESET;
      st.strobe     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  logic [PINS-1:0] fixed_out;

  // Fixed drive per pin; only pins 0 and 2 carry a signal, the rest drive low
  always_comb begin
    fixed_out = '0;
    fixed_out[pfi_routing_pkg::PIN_START_TRIG] = st.trig_cnt != 4'h0;  // RL16 RL14
    fixed_out[pfi_routing_pkg::PIN_POST_TRIG]  = 1'b0;
    fixed_out[pfi_routing_pkg::PIN_CONVERT]    = !(st.conv_cnt != 4'h0); // RL16
  end

  // Driver off until software enables it; the far side must then keep off
  assign pin_out_o      = fixed_out;                               // RL1 RL3
  assign pin_oe_o       = st.pin_oe;                               // RL15 RL5
  assign dedicated_oe_o = st.control[pfi_routing_pkg::CTL_DEDIC_OE]; // RL4
  assign acquiring_o    = st.acq != 2'(pfi_routing_pkg::ACQ_IDLE);
  assign keep_pretrig_o = st.acq == 2'(pfi_routing_pkg::ACQ_PRE);  // RL19
  assign scan_sample_clock_out_o = st.control[pfi_routing_pkg::CTL_SCAN_SAMPLE_CLOCK_OUT_EN] &
    (st.scan_sample_clock_out ^ st.control[pfi_routing_pkg::CTL_SCAN_SAMPLE_CLOCK_OUT_POL]);   // RL8
  assign external_strobe_n_o = st.control[pfi_routing_pkg::CTL_STROBE_HW] ?
    st.strobe : st.control[pfi_routing_pkg::CTL_STROBE_LVL];       // RL9 RL10
  assign apb_rsp_o.pready  = st.ready;
  assign apb_rsp_o.pslverr = 1'b0;
  assign apb_rsp_o.prdata  = st.rdata;

endmodule

`default_nettype wire

// ---- verification/pin_instrument.sv ----
// Instrument side of the ten function pins: drives each pin the device leaves off.
// Assumes the bench sets the wanted instrument levels on ext_level_i.
`timescale 1ns/1ps
`default_nettype none
module pin_instrument #(
  parameter int N = 10
) (
  input  wire logic [N-1:0] ext_level_i, // Wanted instrument levels
  input  wire logic [N-1:0] dev_out_i,   // Device drive values
  input  wire logic [N-1:0] dev_oe_i,    // Device drive enables
  output logic      [N-1:0] pin_o        // Resolved pin levels
);
  // ==========================================================================
  // Wire resolution: the instrument backs off wherever the device drives,
  // so a pin never sees two drivers fighting
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pin_o[i] = dev_oe_i[i] ? dev_out_i[i] : ext_level_i[i];
    end
  end
endmodule
`default_nettype wire

// ---- verification/pfi_routing_props.sv ----
// Checker for the function pin routing block: timing of its outputs.
// Assumes the scan clock polarity stays at its reset setting.
`timescale 1ns/1ps
`default_nettype none
module pfi_routing_checker #(
  parameter int PINS    = 10,
  parameter int SIGNALS = 13
) (
  input wire logic                      clock_i,                 // Clock
  input wire logic                      nrst_i,                  // Sync reset, low
  input wire pfi_routing_pkg::apb_rsp_t apb_rsp_o,               // APB answer
  input wire logic [PINS-1:0]           pin_out_o,               // Pin values
  input wire logic [PINS-1:0]           pin_oe_o,                // Pin enables
  input wire logic                      convert_pulse_i,         // Conversion
  input wire logic [SIGNALS-1:0]        signal_event_o,          // Routed inputs
  input wire logic                      acquiring_o,             // Running
  input wire logic                      keep_pretrig_o,          // Pre phase
  input wire logic                      scan_sample_clock_out_o, // Scan clock
  input wire logic                      external_strobe_n_o      // Strobe, low
);
  // ==========================================================================
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  ready_one_cycle_a: assert property (apb_rsp_o.pready |=> !apb_rsp_o.pready)
    else $error("pready stood longer than one cycle");
  reset_quiet_a: assert property ($rose(nrst_i) |-> pin_oe_o == '0 && external_strobe_n_o)
    else $error("outputs not quiet after reset");
  trig_pulse_one_a: assert property ($rose(pin_out_o[0]) |=> !pin_out_o[0])
    else $error("start pulse not one cycle");
  trig_starts_acq_a: assert property ($rose(pin_out_o[0]) |-> ##[0:1] acquiring_o)
    else $error("start pulse without acquisition");
  trig_from_idle_a: assert property ($rose(pin_out_o[0]) |-> !$past(acquiring_o))
    else $error("start pulse while already running");
  scan_delay_a: assert property ($rose(scan_sample_clock_out_o) |-> $past(convert_pulse_i, 2))
    else $error("scan clock not two cycles after conversion");
  scan_width_a: assert property ($rose(scan_sample_clock_out_o) |->
    scan_sample_clock_out_o [*8] ##1 !scan_sample_clock_out_o)
    else $error("scan clock width wrong");
  convert_pin_a: assert property (convert_pulse_i && acquiring_o |-> ##[1:2] !pin_out_o[2])
    else $error("conversion not shown on pin two");
  keep_in_acq_a: assert property ($rose(keep_pretrig_o) |-> $rose(pin_out_o[0]))
    else $error("early samples kept outside acquisition");
  event_pulse_a: assert property (signal_event_o[0] |=> !signal_event_o[0])
    else $error("start event longer than one cycle");
endmodule

bind pfi_trigger_routing pfi_routing_checker #(.PINS(PINS), .SIGNALS(SIGNALS)) u_checker (
  .clock_i(clock_i), .nrst_i(nrst_i), .apb_rsp_o(apb_rsp_o), .pin_out_o(pin_out_o),
  .pin_oe_o(pin_oe_o), .convert_pulse_i(convert_pulse_i), .signal_event_o(signal_event_o),
  .acquiring_o(acquiring_o), .keep_pretrig_o(keep_pretrig_o),
  .scan_sample_clock_out_o(scan_sample_clock_out_o),
  .external_strobe_n_o(external_strobe_n_o));
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the function pin routing block.
// Assumes the design package is compiled first; the bench pulses scan_done_i.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================================================
  // Signals
  logic                      clock_i, nrst_i, last0, last_str, ana, conv, acq, keep, scan;
  logic                      str_n, ded, done;
  pfi_routing_pkg::apb_req_t req;
  pfi_routing_pkg::apb_rsp_t rsp;
  logic [9:0]                pins, ext, pout, poe;
  logic [12:0]               sev;
  logic [31:0]               rd, v;
  int                        fail_count, n_tests, cyc, trig_cnt, str_cnt, n, c0;

  pfi_trigger_routing i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .apb_req_i(req),
    .apb_rsp_o(rsp), .pin_in_i(pins), .pin_out_o(pout), .pin_oe_o(poe),
    .analog_trig_i(ana), .convert_pulse_i(conv), .scan_done_i(done),
    .signal_event_o(sev), .acquiring_o(acq), .keep_pretrig_o(keep),
    .scan_sample_clock_out_o(scan), .external_strobe_n_o(str_n), .dedicated_oe_o(ded));
  pin_instrument i_pins (.ext_level_i(ext), .dev_out_i(pout), .dev_oe_i(poe), .pin_o(pins));

  // ==========================================================================
  // Clock, hang guard and edge counters; counting edges keeps short pulses
  // from slipping past while a bus task is busy
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    last0 <= pout[0];
    last_str <= str_n;
    if (pout[0] === 1'b1 && last0 === 1'b0) trig_cnt <= trig_cnt + 1;
    if (str_n === 1'b0 && last_str === 1'b1) str_cnt <= str_cnt + 1;
    if (cyc == 30000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // APB transfer: hold until pready is sampled, then release for one cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clock_i);
    req.penable <= 1'b1;
    do @(posedge clock_i); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic ctl(input logic [31:0] bits);
    apb(1'b1, pfi_routing_pkg::OFS_CONTROL, pfi_routing_pkg::CONTROL_RESET | bits);
  endtask

  task automatic stop_acq();
    apb(1'b1, pfi_routing_pkg::OFS_COMMAND, 32'h0000_0004);
    check("acquiring after stop", 1'b0, acq);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    nrst_i = 1'b0; req = '0; ext = '0; ana = 1'b0; conv = 1'b0; done = 1'b0;
    fail_count = 0; n_tests = 0; cyc = 0; trig_cnt = 0; str_cnt = 0;
    last0 = 1'b0; last_str = 1'b1;
    void'($urandom(27631));
    repeat (6) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    check("pin enables", 10'h000, poe);
    check("strobe idle", 1'b1, str_n);
    apb(1'b0, pfi_routing_pkg::OFS_CONTROL, '0);
    check("control reset", pfi_routing_pkg::CONTROL_RESET, rd);
    apb(1'b0, pfi_routing_pkg::OFS_POST_SCANS, '0);
    check("post scans reset", 32'h0000_0010, rd);
    apb(1'b0, 12'h800, '0);
    check("unmapped read", 32'h0000_0000, rd);
    for (int s = 0; s < 13; s++) begin
      v = $urandom % 10;
      apb(1'b1, pfi_routing_pkg::OFS_SELECT_BASE + 12'(4 * s), v);
      apb(1'b0, pfi_routing_pkg::OFS_SELECT_BASE + 12'(4 * s), '0);
      check("source select", v, {28'h0, rd[3:0]});
    end
    // Park start and posttrigger slots on an absent pin while drivers switch
    apb(1'b1, pfi_routing_pkg::OFS_SELECT_BASE, 32'h0000_000F);
    apb(1'b1, pfi_routing_pkg::OFS_SELECT_BASE + 12'h004, 32'h0000_000F);
    v = $urandom % 1024;
    apb(1'b1, pfi_routing_pkg::OFS_PIN_OE, v);
    check("pin enables", v[9:0], poe);
    apb(1'b1, pfi_routing_pkg::OFS_PIN_OE, 32'h0000_0005);
    // Start from a pin edge; pin 9 falling edge first, pin 1 next, then random
    for (int k = 0; k < 6; k++) begin
      n = (k == 0) ? 9 : ((k == 1) ? 1 : 3 + $urandom % 7);
      v = (k == 0) ? 32'h1 : $urandom % 2;
      ctl({31'h0, k[0]});
      apb(1'b1, pfi_routing_pkg::OFS_SELECT_BASE, n);
      apb(1'b1, pfi_routing_pkg::OFS_POLARITY, v[0] << n);
      ext[n] <= v[0];
      repeat (5) @(posedge clock_i);
      c0 = trig_cnt;
      ext[n] <= ~v[0];
      repeat (8) @(posedge clock_i);
      check("start pulses", c0 + 1, trig_cnt);
      check("acquiring", 1'b1, acq);
      check("keep early samples", k[0], keep);
      ext[n] <= v[0];
      stop_acq();
    end
    // Pretrigger run: software start, posttrigger edge on pin 9, counted scans
    ctl(32'h0000_0001);
    apb(1'b1, pfi_routing_pkg::OFS_POLARITY, 32'h0000_0000);
    apb(1'b1, pfi_routing_pkg::OFS_SELECT_BASE + 12'h004, 32'h0000_0009);
    apb(1'b1, pfi_routing_pkg::OFS_SELECT_BASE + 12'h010, 32'h0000_0009);
    ext[9] <= 1'b0;
    apb(1'b1, pfi_routing_pkg::OFS_COMMAND, 32'h0000_0001);
    check("pretrigger phase", 1'b1, keep);
    ext[9] <= 1'b1;
    repeat (5) @(posedge clock_i);
    check("posttrigger phase", 1'b0, keep);
    check("gate level", 1'b1, sev[pfi_routing_pkg::SIG_GATE]);
    done <= 1'b1;
    repeat (int'(pfi_routing_pkg::POST_SCANS_RESET) - 1) @(posedge clock_i);
    done <= 1'b0;
    @(posedge clock_i);
    check("acquiring before last scan", 1'b1, acq);
    done <= 1'b1;
    @(posedge clock_i);
    done <= 1'b0;
    @(posedge clock_i);
    check("stop after scans", 1'b0, acq);
    // Software start, then a conversion to make the scan clock
    ctl(32'h0000_0002);
    c0 = trig_cnt;
    apb(1'b1, pfi_routing_pkg::OFS_COMMAND, 32'h0000_0001);
    @(posedge clock_i);
    check("software start", c0 + 1, trig_cnt);
    conv <= 1'b1;
    @(posedge clock_i);
    conv <= 1'b0;
    n = 0;
    repeat (16) begin
      @(posedge clock_i);
      if (scan === 1'b1) n++;
    end
    check("scan clock cycles", pfi_routing_pkg::SCAN_WIDTH_CYC, n);
    stop_acq();
    // Threshold trigger as start source
    ctl(32'h0000_0040);
    ana <= 1'b1;
    repeat (4) @(posedge clock_i);
    ana <= 1'b0;
    check("threshold start", 1'b1, acq);
    stop_acq();
    ctl(32'h0000_0080);
    check("dedicated enable", 1'b1, ded);
    ctl(32'h0000_0000);
    apb(1'b1, pfi_routing_pkg::OFS_CONTROL, 32'h0000_0000);
    check("strobe level low", 1'b0, str_n);
    ctl(32'h0000_0000);
    check("strobe level high", 1'b1, str_n);
    // Strobe bursts, fast clock then slow clock
    for (int f = 1; f >= 0; f--) begin
      ctl(32'h0000_0008 | (f << 5));
      c0 = str_cnt;
      apb(1'b1, pfi_routing_pkg::OFS_COMMAND, 32'h0000_0002);
      repeat (16 * (f ? pfi_routing_pkg::STROBE_FAST_CYC : pfi_routing_pkg::STROBE_SLOW_CYC) + 40)
        @(posedge clock_i);
      check("strobe pulses", c0 + pfi_routing_pkg::STROBE_PULSES, str_cnt);
    end
    complete_run();
  end
endmodule
`default_nettype wire
